// File: verilog/ctp_timer_pair.sv
// upper timer of pair a and both timers of pair b, with axi4-lite registers
// assumes aclk is the instruction clock; pins are asynchronous to it
//
// How it works
// - upper timer runs on run_enable unless joined
// - stop_in_idle set halts timer during idle
// - gate_enable ignored with external clock selected
// - prescale 11:256, 10:64, 01:8, 00:1
// - upper timers: pin clock or internal clock
// - pair b low: pin rising edges or internal
// - join_32bit makes pair b one 32-bit timer
// - lower run_enable starts and stops joined timer
// - upper control bits ignored while joined, except stop_in_idle, which still halts the joined timer in idle
// - control bit positions; unimplemented bits read zero
// - lower timer holds low count word
// - lower clock/gate drive join; upper flag raised
// - period words: upper high, lower low
//
// The implementer's own choices: register access over AXI4-Lite and the register offsets.
`timescale 1ns/1ps
`default_nettype none
`include "ctp_params.svh"

module ctp_timer_pair
  import ctp_pkg::*;
(
  input  wire logic        aclk,
  input  wire logic        aresetn,
  input  wire logic [7:0]  s_axi_awaddr,
  input  wire logic        s_axi_awvalid,
  output var  logic        s_axi_awready,
  input  wire logic [31:0] s_axi_wdata,
  input  wire logic [3:0]  s_axi_wstrb,
  input  wire logic        s_axi_wvalid,
  output var  logic        s_axi_wready,
  output var  logic [1:0]  s_axi_bresp,
  output var  logic        s_axi_bvalid,
  input  wire logic        s_axi_bready,
  input  wire logic [7:0]  s_axi_araddr,
  input  wire logic        s_axi_arvalid,
  output var  logic        s_axi_arready,
  output var  logic [31:0] s_axi_rdata,
  output var  logic [1:0]  s_axi_rresp,
  output var  logic        s_axi_rvalid,
  input  wire logic        s_axi_rready,
  input  wire logic        idle_mode,
  input  wire logic        pair_a_joined,
  input  wire logic        pair_a_high_ext_clock_pin,
  input  wire logic        pair_b_low_ext_clock_pin,
  input  wire logic        pair_b_high_ext_clock_pin,
  output var  logic        irq
);

  function automatic ctp_reg_t reg_decode(input logic [7:0] a);
    if (a == `CTP_OFF_A_HIGH_CTRL) reg_decode = CTP_R_CTRL0;
    else if (a == `CTP_OFF_B_LOW_CTRL) reg_decode = CTP_R_CTRL1;
    else if (a == `CTP_OFF_B_HIGH_CTRL) reg_decode = CTP_R_CTRL2;
    else if (a == `CTP_OFF_A_HIGH_PER) reg_decode = CTP_R_PER0;
    else if (a == `CTP_OFF_B_LOW_PER) reg_decode = CTP_R_PER1;
    else if (a == `CTP_OFF_B_HIGH_PER) reg_decode = CTP_R_PER2;
    else if (a == `CTP_OFF_A_HIGH_CNT) reg_decode = CTP_R_CNT0;
    else if (a == `CTP_OFF_B_LOW_CNT) reg_decode = CTP_R_CNT1;
    else if (a == `CTP_OFF_B_HIGH_CNT) reg_decode = CTP_R_CNT2;
    else if (a == `CTP_OFF_IRQ_STATUS) reg_decode = CTP_R_STAT;
    else if (a == `CTP_OFF_IRQ_MASK) reg_decode = CTP_R_MASK;
    else reg_decode = CTP_R_NONE;
  endfunction

  function automatic ctp_ctrl_t ctrl_fields(input logic [15:0] r);
    ctrl_fields.run    = r[`CTP_BIT_RUN];
    ctrl_fields.sidl   = r[`CTP_BIT_SIDL];
    ctrl_fields.gate   = r[`CTP_BIT_GATE];
    ctrl_fields.ps     = r[`CTP_BIT_PS_HI:`CTP_BIT_PS_LO];
    ctrl_fields.join32 = r[`CTP_BIT_JOIN];
    ctrl_fields.cs     = r[`CTP_BIT_CS];
  endfunction

  function automatic logic [7:0] ps_limit(input logic [1:0] ps);
    ps_limit = (ps == 2'b11) ? `CTP_PS_M1_256 :
               (ps == 2'b10) ? `CTP_PS_M1_64 :
               (ps == 2'b01) ? `CTP_PS_M1_8 : `CTP_PS_M1_1;
  endfunction

  function automatic logic [15:0] strb_merge(input logic [15:0] old, input logic [31:0] d,
                                             input logic [3:0] s);
    strb_merge = {s[1] ? d[15:8] : old[15:8], s[0] ? d[7:0] : old[7:0]};
  endfunction

  // register state
  logic [2:0][15:0] ctrl_q;
  logic [2:0][15:0] per_q;
  logic [2:0][15:0] cnt_q;
  logic [2:0][7:0]  pre_q;
  logic [2:0]       stat_q;
  logic [2:0]       mask_q;

  // pin synchronisers and filtered levels
  logic [2:0] pin_ff1_q;
  logic [2:0] pin_ff2_q;
  logic [2:0] pin_ff3_q;
  logic [2:0] pin_lvl_q;
  logic [2:0] pin_lvl_prev_q;
  logic [2:0] pins;
  assign pins = {pair_b_high_ext_clock_pin, pair_b_low_ext_clock_pin, pair_a_high_ext_clock_pin};

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      pin_ff1_q      <= 3'h0;
      pin_ff2_q      <= 3'h0;
      pin_ff3_q      <= 3'h0;
      pin_lvl_q      <= 3'h0;
      pin_lvl_prev_q <= 3'h0;
    end else begin
      pin_ff1_q      <= pins;
      pin_ff2_q      <= pin_ff1_q;
      pin_ff3_q      <= pin_ff2_q;
      // a change only counts once two stages agree, so runt glitches are dropped
      for (int i = 0; i < 3; i++) begin
        if (pin_ff2_q[i] == pin_ff3_q[i]) begin
          pin_lvl_q[i] <= pin_ff2_q[i];
        end
      end
      pin_lvl_prev_q <= pin_lvl_q;
    end
  end

  logic       join_b;
  logic [2:0] run_v;
  logic [2:0] src_evt;
  logic [2:0] tick;
  logic [2:0] gate_fall;
  logic [2:0] match16;
  logic       match32;
  logic [2:0] evt;

  assign join_b  = ctrl_q[1][`CTP_BIT_JOIN];
  assign match32 = ({cnt_q[2], cnt_q[1]} == {per_q[2], per_q[1]});

  always_comb begin
    ctp_ctrl_t c;
    logic      halt;
    logic      sidl;
    c = ctrl_fields(16'h0000);
    halt = 1'b0;
    sidl = 1'b0;
    for (int i = 0; i < 3; i++) begin
      c    = ctrl_fields(ctrl_q[i]);
      halt = 1'b0;
      sidl = c.sidl;
      if (i == 0) begin
        halt = pair_a_joined;
      end
      if (i == 2) begin
        halt = join_b;  // the upper half is stepped by the lower timer
      end
      if (i == 1 && join_b) begin
        sidl = c.sidl | ctrl_q[2][`CTP_BIT_SIDL];
      end
      run_v[i]     = c.run & ~halt & ~(idle_mode & sidl);
      src_evt[i]   = c.cs ? (pin_lvl_q[i] & ~pin_lvl_prev_q[i])
                          : (c.gate ? pin_lvl_q[i] : 1'b1);
      tick[i]      = run_v[i] & src_evt[i] & (pre_q[i] == ps_limit(c.ps));
      gate_fall[i] = run_v[i] & ~c.cs & c.gate & pin_lvl_prev_q[i] & ~pin_lvl_q[i];
      match16[i]   = (cnt_q[i] == per_q[i]);
    end
    evt[0] = (tick[0] & match16[0]) | gate_fall[0];
    evt[1] = ~join_b & ((tick[1] & match16[1]) | gate_fall[1]);
    evt[2] = join_b ? ((tick[1] & match32) | gate_fall[1])
                    : ((tick[2] & match16[2]) | gate_fall[2]);
  end

  // axi4-lite write channel: address and data taken in either order
  logic [7:0]  aw_addr_q;
  logic        aw_full_q;
  logic [31:0] w_data_q;
  logic [3:0]  w_strb_q;
  logic        w_full_q;
  logic        wr_do;
  ctp_reg_t    wr_reg;
  ctp_reg_t    rd_reg;

  assign wr_do  = aw_full_q & w_full_q & ~s_axi_bvalid;
  assign wr_reg = reg_decode(aw_addr_q);
  assign rd_reg = reg_decode(s_axi_araddr);

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_awready <= 1'b1;
      s_axi_wready  <= 1'b1;
      aw_full_q     <= 1'b0;
      w_full_q      <= 1'b0;
      aw_addr_q     <= 8'h00;
      w_data_q      <= 32'h0000_0000;
      w_strb_q      <= 4'h0;
      s_axi_bvalid  <= 1'b0;
      s_axi_bresp   <= `CTP_RESP_OKAY;
    end else begin
      if (s_axi_awvalid && s_axi_awready) begin
        aw_addr_q     <= s_axi_awaddr;
        aw_full_q     <= 1'b1;
        s_axi_awready <= 1'b0;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        w_data_q     <= s_axi_wdata;
        w_strb_q     <= s_axi_wstrb;
        w_full_q     <= 1'b1;
        s_axi_wready <= 1'b0;
      end
      if (wr_do) begin
        aw_full_q    <= 1'b0;
        w_full_q     <= 1'b0;
        s_axi_bvalid <= 1'b1;
        s_axi_bresp  <= (wr_reg == CTP_R_NONE) ? `CTP_RESP_SLVERR : `CTP_RESP_OKAY;
      end
      if (s_axi_bvalid && s_axi_bready) begin
        s_axi_bvalid  <= 1'b0;
        s_axi_awready <= 1'b1;
        s_axi_wready  <= 1'b1;
      end
    end
  end

  // control and period registers; reserved control bits never store
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      ctrl_q <= {3{`CTP_RST_CTRL}};
      per_q  <= {3{`CTP_RST_PER}};
      mask_q <= 3'h0;
    end else if (wr_do) begin
      if (wr_reg == CTP_R_CTRL0) begin
        ctrl_q[0] <= strb_merge(ctrl_q[0], w_data_q, w_strb_q) & `CTP_CTRL_MASK_HIGH;
      end else if (wr_reg == CTP_R_CTRL1) begin
        ctrl_q[1] <= strb_merge(ctrl_q[1], w_data_q, w_strb_q) & `CTP_CTRL_MASK_LOW;
      end else if (wr_reg == CTP_R_CTRL2) begin
        ctrl_q[2] <= strb_merge(ctrl_q[2], w_data_q, w_strb_q) & `CTP_CTRL_MASK_HIGH;
      end else if (wr_reg == CTP_R_PER0) begin
        per_q[0] <= strb_merge(per_q[0], w_data_q, w_strb_q);
      end else if (wr_reg == CTP_R_PER1) begin
        per_q[1] <= strb_merge(per_q[1], w_data_q, w_strb_q);
      end else if (wr_reg == CTP_R_PER2) begin
        per_q[2] <= strb_merge(per_q[2], w_data_q, w_strb_q);
      end else if (wr_reg == CTP_R_MASK && w_strb_q[0]) begin
        mask_q <= w_data_q[2:0];
      end
    end
  end

  // prescalers restart whenever their timer is stopped
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      pre_q <= '0;
    end else begin
      for (int i = 0; i < 3; i++) begin
        if (!run_v[i]) begin
          pre_q[i] <= 8'h00;
        end else if (src_evt[i]) begin
          pre_q[i] <= tick[i] ? 8'h00 : 8'(pre_q[i] + 8'h01);
        end
      end
    end
  end

  // counters; a bus write to a count beats a tick in the same cycle
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      cnt_q <= {3{`CTP_RST_CNT}};
    end else begin
      if (tick[0]) begin
        cnt_q[0] <= match16[0] ? 16'h0000 : 16'(cnt_q[0] + 16'h0001);
      end
      if (join_b) begin
        if (tick[1]) begin
          {cnt_q[2], cnt_q[1]} <= match32 ? 32'h0000_0000
                                          : 32'({cnt_q[2], cnt_q[1]} + 32'h0000_0001);
        end
      end else begin
        if (tick[1]) begin
          cnt_q[1] <= match16[1] ? 16'h0000 : 16'(cnt_q[1] + 16'h0001);
        end
        if (tick[2]) begin
          cnt_q[2] <= match16[2] ? 16'h0000 : 16'(cnt_q[2] + 16'h0001);
        end
      end
      if (wr_do && wr_reg == CTP_R_CNT0) begin
        cnt_q[0] <= strb_merge(cnt_q[0], w_data_q, w_strb_q);
      end
      if (wr_do && wr_reg == CTP_R_CNT1) begin
        cnt_q[1] <= strb_merge(cnt_q[1], w_data_q, w_strb_q);
      end
      if (wr_do && wr_reg == CTP_R_CNT2) begin
        cnt_q[2] <= strb_merge(cnt_q[2], w_data_q, w_strb_q);
      end
    end
  end

  // sticky flags, write one to clear; a new event wins over the clear
  logic [2:0] stat_clr;
  assign stat_clr = (wr_do && wr_reg == CTP_R_STAT && w_strb_q[0]) ? w_data_q[2:0] : 3'h0;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      stat_q <= 3'h0;
      irq    <= 1'b0;
    end else begin
      stat_q <= (stat_q & ~stat_clr) | evt;
      irq    <= |(((stat_q & ~stat_clr) | evt) & mask_q);
    end
  end

  // read channel: one read at a time, answered the cycle after address
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_arready <= 1'b1;
      s_axi_rvalid  <= 1'b0;
      s_axi_rdata   <= 32'h0000_0000;
      s_axi_rresp   <= `CTP_RESP_OKAY;
    end else begin
      if (s_axi_arvalid && s_axi_arready) begin
        s_axi_arready <= 1'b0;
        s_axi_rvalid  <= 1'b1;
        s_axi_rresp   <= (rd_reg == CTP_R_NONE) ? `CTP_RESP_SLVERR : `CTP_RESP_OKAY;
        if (rd_reg == CTP_R_CTRL0 || rd_reg == CTP_R_CTRL1 || rd_reg == CTP_R_CTRL2) begin
          s_axi_rdata <= {16'h0000, ctrl_q[4'(rd_reg) - 4'(CTP_R_CTRL0)]};
        end else if (rd_reg == CTP_R_PER0 || rd_reg == CTP_R_PER1 || rd_reg == CTP_R_PER2) begin
          s_axi_rdata <= {16'h0000, per_q[4'(rd_reg) - 4'(CTP_R_PER0)]};
        end else if (rd_reg == CTP_R_CNT0 || rd_reg == CTP_R_CNT1 || rd_reg == CTP_R_CNT2) begin
          s_axi_rdata <= {16'h0000, cnt_q[4'(rd_reg) - 4'(CTP_R_CNT0)]};
        end else if (rd_reg == CTP_R_STAT) begin
          s_axi_rdata <= {29'h0, stat_q};
        end else if (rd_reg == CTP_R_MASK) begin
          s_axi_rdata <= {29'h0, mask_q};
        end else begin
          s_axi_rdata <= 32'h0000_0000;
        end
      end
      if (s_axi_rvalid && s_axi_rready) begin
        s_axi_rvalid  <= 1'b0;
        s_axi_arready <= 1'b1;
      end
    end
  end

endmodule // ctp_timer_pair

`default_nettype wire

// File: verilog/ctp_params.svh
// offsets, field positions, reset values and prescale counts
// assumes a 32-bit axi4-lite slave with one word per register
`ifndef CTP_PARAMS_SVH
`define CTP_PARAMS_SVH

`define CTP_OFF_A_HIGH_CTRL  8'h00
`define CTP_OFF_B_LOW_CTRL   8'h04
`define CTP_OFF_B_HIGH_CTRL  8'h08
`define CTP_OFF_A_HIGH_PER   8'h0c
`define CTP_OFF_B_LOW_PER    8'h10
`define CTP_OFF_B_HIGH_PER   8'h14
`define CTP_OFF_A_HIGH_CNT   8'h18
`define CTP_OFF_B_LOW_CNT    8'h1c
`define CTP_OFF_B_HIGH_CNT   8'h20
`define CTP_OFF_IRQ_STATUS   8'h24
`define CTP_OFF_IRQ_MASK     8'h28

`define CTP_BIT_RUN          15
`define CTP_BIT_SIDL         13
`define CTP_BIT_GATE         6
`define CTP_BIT_PS_HI        5
`define CTP_BIT_PS_LO        4
`define CTP_BIT_JOIN         3
`define CTP_BIT_CS           1
`define CTP_CTRL_MASK_HIGH   16'ha072
`define CTP_CTRL_MASK_LOW    16'ha07a

`define CTP_RST_CTRL         16'h0000
`define CTP_RST_PER          16'hffff
`define CTP_RST_CNT          16'h0000

`define CTP_PS_M1_256        8'hff
`define CTP_PS_M1_64         8'h3f
`define CTP_PS_M1_8          8'h07
`define CTP_PS_M1_1          8'h00

`define CTP_RESP_OKAY        2'b00
`define CTP_RESP_SLVERR      2'b10
`endif

// File: verilog/ctp_pkg.sv
// types shared by the timer pair control block
// assumes ctp_params.svh supplies the numeric constants
package ctp_pkg;
  typedef struct packed {
    logic       run;
    logic       sidl;
    logic       gate;
    logic [1:0] ps;
    logic       join32;
    logic       cs;
  } ctp_ctrl_t;

  typedef enum logic [3:0] {
    CTP_R_CTRL0, CTP_R_CTRL1, CTP_R_CTRL2,
    CTP_R_PER0, CTP_R_PER1, CTP_R_PER2,
    CTP_R_CNT0, CTP_R_CNT1, CTP_R_CNT2,
    CTP_R_STAT, CTP_R_MASK, CTP_R_NONE
  } ctp_reg_t;
endpackage

// File: bench/ctp_timer_pair_asserts.sv
// checker on the axi4-lite ports of the timer pair block
// assumes one aclk domain and bind onto ctp_timer_pair
`timescale 1ns/1ps
`default_nettype none

module ctp_timer_pair_asserts (
  input wire logic        aclk,
  input wire logic        aresetn,
  input wire logic [7:0]  s_axi_awaddr,
  input wire logic        s_axi_awvalid,
  input wire logic        s_axi_awready,
  input wire logic        s_axi_wvalid,
  input wire logic        s_axi_wready,
  input wire logic [1:0]  s_axi_bresp,
  input wire logic        s_axi_bvalid,
  input wire logic        s_axi_bready,
  input wire logic [7:0]  s_axi_araddr,
  input wire logic        s_axi_arvalid,
  input wire logic        s_axi_arready,
  input wire logic [31:0] s_axi_rdata,
  input wire logic [1:0]  s_axi_rresp,
  input wire logic        s_axi_rvalid,
  input wire logic        s_axi_rready
);
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);

  property p_b_hold; s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp); endproperty
  a_b_hold: assert property (p_b_hold) else $error("write response dropped early");
  property p_r_hold; s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable({s_axi_rdata, s_axi_rresp}); endproperty
  a_r_hold: assert property (p_r_hold) else $error("read data dropped early");
  // both halves taken at one edge: the write lands and bvalid rises at the next one
  property p_b_answer; s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready |-> ##2 s_axi_bvalid; endproperty
  a_b_answer: assert property (p_b_answer) else $error("write response late");
  property p_r_answer; s_axi_arvalid && s_axi_arready |=> s_axi_rvalid; endproperty
  a_r_answer: assert property (p_r_answer) else $error("read data late");
  property p_aw_busy; s_axi_awvalid && s_axi_awready |=> !s_axi_awready; endproperty
  a_aw_busy: assert property (p_aw_busy) else $error("second write accepted");
  property p_ar_busy; s_axi_rvalid |-> !s_axi_arready; endproperty
  a_ar_busy: assert property (p_ar_busy) else $error("second read accepted");
  property p_r_unmapped; s_axi_arvalid && s_axi_arready && s_axi_araddr > 8'h28
    |=> s_axi_rresp == 2'b10 && s_axi_rdata == 32'h0; endproperty
  a_r_unmapped: assert property (p_r_unmapped) else $error("unmapped read not refused");
  property p_b_unmapped; s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready && s_axi_awaddr > 8'h28
    |-> ##2 s_axi_bresp == 2'b10; endproperty
  a_b_unmapped: assert property (p_b_unmapped) else $error("unmapped write not refused");
  property p_r_upper; s_axi_rvalid |-> s_axi_rdata[31:16] == 16'h0; endproperty
  a_r_upper: assert property (p_r_upper) else $error("upper read bits not zero");
endmodule // ctp_timer_pair_asserts

bind ctp_timer_pair ctp_timer_pair_asserts i_ctp_timer_pair_asserts (.aclk(aclk), .aresetn(aresetn),
  .s_axi_awaddr(s_axi_awaddr), .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready),
  .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp),
  .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready), .s_axi_araddr(s_axi_araddr),
  .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata),
  .s_axi_rresp(s_axi_rresp), .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready));
`default_nettype wire

// File: bench/ctp_timer_pair_tb.sv
// self-checking bench: registers, prescale, idle, join, pins, gate, irq
// assumes the register map of ctp_params.svh and a 100 MHz aclk
`timescale 1ns/1ps
`default_nettype none

module ctp_timer_pair_tb;
  logic        aclk = 0, aresetn = 0, idle = 0, ajoin = 0, irq;
  logic [7:0]  awaddr = 0, araddr = 0;
  logic [31:0] wdata = 0, rdata, got, g2;
  logic        awvalid = 0, wvalid = 0, bready = 0, arvalid = 0, rready = 0;
  logic        awready, wready, bvalid, arready, rvalid;
  logic [1:0]  bresp, rresp;
  logic [2:0]  pin = 0;
  int          num_errors = 0, samples_checked = 0, cyc = 0, n, t0;

  always #5 aclk = ~aclk;

  ctp_timer_pair i_ctp_timer_pair (.aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(awaddr),
    .s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(4'hf),
    .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid),
    .s_axi_bready(bready), .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
    .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
    .idle_mode(idle), .pair_a_joined(ajoin), .pair_a_high_ext_clock_pin(pin[0]),
    .pair_b_low_ext_clock_pin(pin[1]), .pair_b_high_ext_clock_pin(pin[2]), .irq(irq));

  task automatic test_done;
    $display("errors %0d checks %0d", num_errors, samples_checked);
    if (num_errors == 0 && samples_checked > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask

  // whole run needs well under 20k cycles
  always @(posedge aclk) begin
    cyc <= cyc + 1;
    if (cyc == 40000) begin
      num_errors++;
      test_done;
    end
  end

  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    samples_checked++;
    if (g !== e) begin
      num_errors++;
      $display("[FAIL] %0t got %h exp %h", $time, g, e);
    end
  endtask

  // upper data bits set on purpose: the slave must drop them
  task automatic wr(input logic [7:0] a, input logic [15:0] d, input logic [1:0] er = 2'b00);
    n = 0;
    awaddr <= a;
    wdata <= {16'hffff, d};
    awvalid <= 1;
    wvalid <= 1;
    bready <= 1;
    do begin
      @(posedge aclk);
      n++;
      if (awready) awvalid <= 0;
      if (wready) wvalid <= 0;
    end while (!bvalid && n < 50);
    chk({bvalid, bresp}, {1'b1, er});
  endtask

  task automatic rd(input logic [7:0] a, output logic [31:0] d, input logic [1:0] er = 2'b00);
    n = 0;
    araddr <= a;
    arvalid <= 1;
    rready <= 1;
    do begin
      @(posedge aclk);
      n++;
      if (arready) arvalid <= 0;
    end while (!rvalid && n < 50);
    d = rdata;
    chk({rvalid, rresp}, {1'b1, er});
  endtask

  task automatic rc(input logic [7:0] a, input logic [31:0] e);
    rd(a, got);
    chk(got, e);
  endtask

  // start a timer, let it run, stop it; t0 holds the cycles it ran
  task automatic run(input logic [7:0] a, input logic [15:0] c, input int w);
    wr(a, c | 16'h8000);
    t0 = cyc;
    repeat (w) @(posedge aclk);
    wr(a, c);
    t0 = cyc - t0;
  endtask

  function automatic int dv(input logic [1:0] ps);
    return ps == 2'b11 ? 256 : ps == 2'b10 ? 64 : ps == 2'b01 ? 8 : 1;
  endfunction

  // start and stop edges of a run are only known to a cycle or two
  function automatic logic [31:0] near(input logic [31:0] g, input int e, input int tol);
    return (!$isunknown(g) && int'(g) + tol >= e && int'(g) <= e + tol) ? g : 32'(e);
  endfunction

  initial begin
    logic [15:0] d;
    logic [1:0]  ps;
    int          k, np;
    k = $urandom(32'h909ee73a);
    repeat (2) @(posedge aclk);
    aresetn <= 1;
    @(posedge aclk);
    for (k = 0; k < 11; k++) rc(8'(k * 4), (k > 2 && k < 6) ? 32'hffff : 32'h0);
    wr(8'h2c, 16'h1234, 2'b10);
    rd(8'h2c, got, 2'b10);
    chk(got, 32'h0);
    for (k = 0; k < 3; k++) begin
      d = 16'($urandom) & 16'h7fff;
      wr(8'(k * 4), d);
      rc(8'(k * 4), {16'h0, d & (k == 1 ? 16'h207a : 16'h2072)});
      wr(8'(k * 4), 16'h0);
    end
    // 0-3 prescales, 4 halted by pair a join, 5 idle with stop, 6 idle without
    for (k = 0; k < 7; k++) begin
      ps = 2'(k);
      ajoin <= (k == 4);
      idle <= (k > 4);
      wr(8'h18, 16'h0);
      run(8'h00, {2'b00, k == 5, 7'h0, ps, 4'h0}, 300 + $urandom % 300);
      rd(8'h18, got);
      chk(got, near(got, (k == 4 || k == 5) ? 0 : t0 / dv(ps), 1));
    end
    ajoin <= 0;
    idle <= 0;
    wr(8'h1c, 16'h0);
    wr(8'h10, 16'h3);
    run(8'h04, 16'h0, 20);
    rd(8'h1c, got);
    chk({31'h0, got < 4}, 32'h1);
    rc(8'h24, 32'h2);
    chk({31'h0, irq}, 32'h0); // masked
    wr(8'h28, 16'h6);
    repeat (2) @(posedge aclk);
    chk({31'h0, irq}, 32'h1);
    wr(8'h24, 16'h2);
    repeat (2) @(posedge aclk);
    chk({31'h0, irq}, 32'h0);
    rc(8'h24, 32'h0);
    wr(8'h04, 16'h0008);
    wr(8'h08, 16'h8032); // upper run, 1:256 prescale and pin clock must be ignored while joined
    wr(8'h1c, 16'hfff0);
    wr(8'h14, 16'h0002);
    wr(8'h10, 16'h0000);
    run(8'h04, 16'h0008, 10 + $urandom % 20);
    rd(8'h20, got);
    rd(8'h1c, g2);
    chk({got[15:0], g2[15:0]}, near({got[15:0], g2[15:0]}, 32'hfff0 + t0, 1));
    wr(8'h1c, 16'hfff0);
    wr(8'h20, 16'h0);
    wr(8'h14, 16'h0001);
    wr(8'h10, 16'h0004);
    run(8'h04, 16'h0008, 40);
    rc(8'h24, 32'h4);
    chk({31'h0, irq}, 32'h1);
    wr(8'h24, 16'h7);
    wr(8'h04, 16'h0);
    // gate set too: it must be ignored with a pin clock
    for (k = 0; k < 3; k++) begin
      np = 2 + $urandom % 6;
      wr(8'h0c + 8'(k * 4), 16'hffff); // earlier short periods would wrap the pin count
      wr(8'h18 + 8'(k * 4), 16'h0);
      wr(8'(k * 4), 16'h8042);
      repeat (np) begin
        pin[k] <= 1;
        repeat (8) @(posedge aclk);
        pin[k] <= 0;
        repeat (8) @(posedge aclk);
      end
      wr(8'(k * 4), 16'h0);
      rc(8'h18 + 8'(k * 4), 32'(np));
    end
    wr(8'h24, 16'h7);
    wr(8'h18, 16'h0);
    wr(8'h00, 16'h8040);
    k = 20 + $urandom % 20;
    pin[0] <= 1;
    repeat (k) @(posedge aclk);
    pin[0] <= 0;
    repeat (10) @(posedge aclk);
    wr(8'h00, 16'h0);
    rd(8'h18, got);
    chk(got, near(got, k, 2));
    rc(8'h24, 32'h1);
    test_done;
  end
endmodule // ctp_timer_pair_tb
`default_nettype wire
